// File: include/nsc_pkg.sv
// package of constants and carriers for the nand status and identifier controller
package nsc_pkg;
    // ***********************************************
    // axi4-lite register map of the controller
    // ***********************************************
    localparam logic [7:0] NSC_REG_CTRL = 8'h00;
    localparam logic [7:0] NSC_REG_STAT = 8'h04;
    localparam logic [7:0] NSC_REG_ID = 8'h08;
    localparam logic [7:0] NSC_REG_BAD = 8'h0c;
    localparam logic [7:0] NSC_REG_FIFO = 8'h10;
    localparam logic [7:0] NSC_REG_ADDR = 8'h14;
    // ctrl fields: bit0 start, bits3:1 operation, bit4 write-protect release
    localparam int NSC_CTRL_START = 0;
    localparam int NSC_CTRL_OP_LSB = 1;
    localparam int NSC_CTRL_WP = 4;
    localparam logic [2:0] NSC_OP_RESET = 3'h0;
    localparam logic [2:0] NSC_OP_STATUS = 3'h1;
    localparam logic [2:0] NSC_OP_ID = 3'h2;
    localparam logic [2:0] NSC_OP_BADCHK = 3'h3;
    localparam logic [2:0] NSC_OP_READ = 3'h4;
    // ***********************************************
    // device command codes and status bits
    // ***********************************************
    localparam logic [7:0] NSC_CMD_RESET = 8'hff;
    localparam logic [7:0] NSC_CMD_STATUS = 8'h70;
    localparam logic [7:0] NSC_CMD_ID = 8'h90;
    localparam logic [7:0] NSC_CMD_READ0 = 8'h00;
    localparam logic [7:0] NSC_CMD_READ1 = 8'h30;
    localparam logic [7:0] NSC_ERASED = 8'hff;
    localparam int NSC_ST_FAIL = 0;
    localparam int NSC_ST_FAIL_PREV = 1;
    localparam int NSC_ST_CTRL_IDLE = 5;
    localparam int NSC_ST_READY = 6;
    localparam int NSC_ST_NOT_WP = 7;
    // spare area column of a byte-wide 2 KB page
    localparam logic [15:0] NSC_SPARE_COL = 16'h0800;
    // ***********************************************
    // timing
    // ***********************************************
    localparam int NSC_CLK_PS = 8000;
    localparam int NSC_STROBE_NS = 30;
    localparam int NSC_STROBE_CYC = (NSC_STROBE_NS * 1000 + NSC_CLK_PS - 1) / NSC_CLK_PS;
    localparam int NSC_WB_NS = 100;
    localparam int NSC_WB_CYC = (NSC_WB_NS * 1000 + NSC_CLK_PS - 1) / NSC_CLK_PS;
    localparam int NSC_RST_MAX_US = 500;
    localparam int NSC_RST_TMO_CYC = NSC_RST_MAX_US * 1000000 / NSC_CLK_PS;
    localparam int NSC_FIFO_DEPTH = 8;
    // ***********************************************
    // pin carrier
    // ***********************************************
    typedef struct packed {
        logic cs_n;
        logic cmd_latch;
        logic addr_latch;
        logic wr_n;
        logic rd_n;
        logic wp_n;
        logic [7:0] dq_out;
        logic dq_oe;
    } nsc_pins_s;
endpackage

// File: sim/nsc_ctrl_assertions.sv
// checker of the nand controller pin and bus behaviour
`timescale 1ns/1ps
`default_nettype none
module nsc_ctrl_assertions
    import nsc_pkg::*;
#(
    parameter int RST_TMO_CYC = NSC_RST_TMO_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // watched ports
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire nsc_pins_s o_pins,
    input wire logic i_ready_busy_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // ********
    // pin sequencing
    // ********
    a_wp_steady_strobe: assert property (!o_pins.wr_n |=> $stable(o_pins.wp_n))
        else $error("write protect moved inside a write strobe");
    a_cs_frames_strobe: assert property ((!o_pins.wr_n || !o_pins.rd_n) |-> !o_pins.cs_n)
        else $error("strobe outside chip select");
    a_write_drives_bus: assert property (!o_pins.wr_n |-> o_pins.dq_oe && o_pins.rd_n)
        else $error("write strobe without bus drive");
    a_wr_two_low: assert property ($fell(o_pins.wr_n) |=> !o_pins.wr_n ##1 o_pins.wr_n)
        else $error("write strobe width wrong");
    a_no_read_busy: assert property (!i_ready_busy_n |-> o_pins.rd_n)
        else $error("data read while device busy");
    a_no_erase_cmd: assert property (($fell(o_pins.wr_n) && o_pins.cmd_latch) |->
        o_pins.dq_out != 8'h60)
        else $error("erase issued");
    // ********
    // register bus
    // ********
    a_bvalid_holds: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped or changed");
    c_reset_cmd: cover property ($fell(o_pins.wr_n) && o_pins.cmd_latch && o_pins.dq_out == 8'hff);
    c_id_cmd: cover property ($fell(o_pins.wr_n) && o_pins.cmd_latch && o_pins.dq_out == 8'h90);
    c_page_cmd: cover property ($fell(o_pins.wr_n) && o_pins.cmd_latch && o_pins.dq_out == 8'h30);
endmodule
bind nsc_ctrl nsc_ctrl_assertions #(.RST_TMO_CYC(RST_TMO_CYC)) nsc_ctrl_assertions_i (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_pins(o_pins),
    .i_ready_busy_n(i_ready_busy_n));
`default_nettype wire

// File: sim/nsc_ctrl_tb_top.sv
// testbench of the nand status, identifier and bad-block controller
`timescale 1ns/1ps
`default_nettype none
module nsc_ctrl_tb_top;
    import nsc_pkg::*;
    localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
    localparam logic [7:0] DEVICE = 8'h3c; // arbitrary value
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rb_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] dq;
    nsc_pins_s pins;
    int num_errors = 0;
    int check_count = 0;
    nsc_ctrl #(.RST_TMO_CYC(1000)) nsc_ctrl_i (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .o_pins(pins), .i_dq(dq), .i_ready_busy_n(rb_n));
    nsc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .BUSY_NS(1000))
        nsc_flash_model_i (.i_pins(pins), .o_dq(dq), .o_ready_busy_n(rb_n));
    initial forever #4 i_ref_clk = ~i_ref_clk;
    // ********
    // shared tasks
    // ********
    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n);
        if (n > 300) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    // requests move right after a rising edge; handshakes are judged mid-cycle
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_hit, w_hit, b_hit;
        n = 0;
        b_hit = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hit) begin
            @(negedge i_ref_clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid === 1'b1;
            @(posedge i_ref_clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            bound(++n);
        end
        bready <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        int n;
        logic ar_hit, r_hit;
        n = 0;
        r_hit = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hit) begin
            @(negedge i_ref_clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid === 1'b1;
            d = rdata;
            @(posedge i_ref_clk);
            if (ar_hit) arvalid <= 1'b0;
            bound(++n);
        end
        rready <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    // protect level is set first, since a change is ignored once the operation runs
    task automatic run_op(input logic [2:0] op, input logic wp);
        logic [31:0] d;
        int n;
        n = 0;
        axi_write(NSC_REG_CTRL, {27'h0, wp, op, 1'b0});
        axi_write(NSC_REG_CTRL, {27'h0, wp, op, 1'b1});
        d = 32'h1;
        while (d[0] !== 1'b0) begin
            axi_read(NSC_REG_CTRL, d);
            bound(++n);
        end
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_regs();
        logic [31:0] d;
        axi_read(NSC_REG_CTRL, d);
        check(d, 32'h0);
        axi_read(8'h1c, d);
        check(d, 32'h0);
        check({31'h0, pins.wp_n}, 32'h0);
    endtask
    task automatic t_reset_cmd();
        logic [31:0] d;
        run_op(NSC_OP_RESET, 1'b0);
        axi_read(NSC_REG_STAT, d);
        check({31'h0, d[9]}, 32'h0);
    endtask
    task automatic t_status();
        logic [31:0] d;
        for (int wp = 1; wp >= 0; wp--) begin
            run_op(NSC_OP_STATUS, wp[0]);
            axi_read(NSC_REG_STAT, d);
            check({24'h0, d[7:0]}, {24'h0, wp[0], 7'h60});
            check({31'h0, pins.wp_n}, {31'h0, wp[0]});
        end
    endtask
    task automatic t_id();
        logic [31:0] d;
        run_op(NSC_OP_ID, 1'b0);
        axi_read(NSC_REG_ID, d);
        check(d, {8'h1d, 8'h80, DEVICE, MAKER});
    endtask
    task automatic t_bad();
        logic [31:0] d;
        logic [15:0] blks [4] = '{16'h0000, 16'h0005, 16'h0006, 16'h0007};
        logic bads [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            axi_write(NSC_REG_ADDR, {16'h0, blks[i]});
            run_op(NSC_OP_BADCHK, 1'b0);
            axi_read(NSC_REG_BAD, d);
            check({15'h0, d[16:0]}, {15'h0, bads[i], blks[i]});
        end
    endtask
    task automatic t_fifo();
        logic [31:0] d;
        axi_write(NSC_REG_ADDR, 32'h7);
        for (int i = 0; i < 8; i++) run_op(NSC_OP_READ, 1'b0);
        for (int i = 0; i < 9; i++) begin
            axi_read(NSC_REG_FIFO, d);
            if (i < 8) check({23'h0, d[8:0]}, 32'h1ff);
            else check({31'h0, d[8]}, 32'h0);
            if (i == 0) check({31'h0, d[9]}, 32'h1);
        end
    endtask
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        t_regs();
        t_reset_cmd();
        t_status();
        t_id();
        t_bad();
        t_fifo();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: sim/nsc_flash_model.sv
// behavioural model of the flash device: status, identifier, page read, markers
`timescale 1ns/1ps
`default_nettype none
module nsc_flash_model
    import nsc_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3c, // arbitrary value
    parameter int BUSY_NS = 1000
) (
    // pins from the controller
    input wire nsc_pins_s i_pins,
    // pins to the controller
    output logic [7:0] o_dq,
    output logic o_ready_busy_n
);
    logic [7:0] cmd = 8'h00;
    logic [7:0] adr [0:4];
    logic [7:0] last = 8'h00;
    logic [7:0] val;
    logic [9:0] blk;
    logic marked;
    int acnt = 0;
    int idx = 0;
    initial o_ready_busy_n = 1'b1;
    always @(posedge i_pins.wr_n) begin
        if (i_pins.cmd_latch) begin
            cmd = i_pins.dq_out;
            idx = 0;
            if (cmd != NSC_CMD_READ1) acnt = 0;
            if (cmd == NSC_CMD_RESET || cmd == NSC_CMD_READ1) begin
                o_ready_busy_n = 1'b0;
                #(BUSY_NS) o_ready_busy_n = 1'b1;
            end
        end else if (i_pins.addr_latch && acnt < 5) begin
            adr[acnt] = i_pins.dq_out;
            acnt = acnt + 1;
        end
    end
    // blocks 5 and 6 carry factory markers on page one and page two; block 0 stays good
    assign blk = {adr[3], adr[2][7:6]};
    assign marked = {adr[1], adr[0]} == NSC_SPARE_COL && idx == 0 &&
        ((blk == 10'h005 && adr[2][5:0] == 6'h00) || (blk == 10'h006 && adr[2][5:0] == 6'h01));
    always_comb begin
        case (cmd)
            // no program or erase is held, so a protect drop has nothing to abort
            NSC_CMD_STATUS: val = {i_pins.wp_n, {2{o_ready_busy_n}}, 5'h00};
            NSC_CMD_ID: val = idx == 0 ? MAKER_CODE : idx == 1 ? DEVICE_CODE :
                idx == 2 ? 8'h80 : 8'h1d;
            NSC_CMD_READ1: val = marked ? 8'h00 : NSC_ERASED;
            default: val = NSC_ERASED;
        endcase
    end
    // a released bus shows the inverse of the last byte so a stale sample cannot match
    assign o_dq = (!i_pins.cs_n && !i_pins.rd_n) ? val : ~last;
    always @(posedge i_pins.rd_n) begin
        last = val;
        idx = idx + 1;
    end
endmodule
`default_nettype wire

// File: verilog/nsc_ctrl.sv
// host-side nand controller: reset, status poll, identifier read, bad-block check
//
// Behaviour
// - write protect set before write strobe rises
// - chip select may drop between transfers
// - non-ones marker on page one/two: bad; block 0 is reported good whatever its marker says
// - read markers before any erase
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module nsc_ctrl
    import nsc_pkg::*;
#(
    parameter int RST_TMO_CYC = NSC_RST_TMO_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // axi4-lite slave
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // nand pins
    output nsc_pins_s o_pins,
    input wire logic [7:0] i_dq,
    input wire logic i_ready_busy_n
);
    // ***********************************************
    // state
    // ***********************************************
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_CMD = 7'b0000010,
        S_ADDR = 7'b0000100,
        S_CMD2 = 7'b0001000,
        S_WAIT = 7'b0010000,
        S_DATA = 7'b0100000,
        S_DONE = 7'b1000000
    } nsc_state_e;

    nsc_state_e state;
    logic [2:0] op;
    logic [7:0] cmd;
    logic [2:0] addr_idx;
    logic [2:0] data_left;
    logic [2:0] addr_cnt;
    logic [1:0] phase;
    logic [3:0] tick;
    logic [31:0] wait_cnt;
    logic busy;
    logic timeout;
    logic wp_release;
    logic [15:0] blk_row;
    logic [7:0] status_byte;
    logic [31:0] id_word;
    logic bad_flag;
    logic checked;
    logic page2;
    logic [1:0] id_pos;
    logic start;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic [7:0] addr_byte;
    logic strobe_done;

    // ***********************************************
    // axi4-lite write path
    // ***********************************************
    assign o_awready = !aw_hold;
    assign o_wready = !w_hold;
    assign o_bresp = 2'b00;
    assign start = aw_hold && w_hold && !o_bvalid;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            o_bvalid <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_hold <= 1'b1;
                w_data <= i_wdata;
            end
            if (start) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                o_bvalid <= 1'b1;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ***********************************************
    // axi4-lite read path
    // ***********************************************
    assign o_arready = !o_rvalid;
    assign o_rresp = 2'b00;
    assign fifo_pop = i_arvalid && o_arready && (i_araddr == NSC_REG_FIFO);

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            unique case (i_araddr)
                NSC_REG_CTRL: o_rdata <= {27'h0, wp_release, op, busy};
                NSC_REG_STAT: o_rdata <= {22'h0, timeout, checked, status_byte};
                NSC_REG_ID: o_rdata <= id_word;
                NSC_REG_BAD: o_rdata <= {15'h0, bad_flag, blk_row};
                NSC_REG_FIFO: o_rdata <= {22'h0, !fifo_in_ready, fifo_out_valid, fifo_out_data};
                NSC_REG_ADDR: o_rdata <= {16'h0, blk_row};
                default: o_rdata <= 32'h0;
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ***********************************************
    // register write effects
    // ***********************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wp_release <= 1'b0;
            blk_row <= '0;
        end else if (start && (aw_addr == NSC_REG_CTRL) && i_wstrb[0]) begin
            // protect level changes only while idle, so it settles before any strobe
            if (!busy) begin
                wp_release <= w_data[NSC_CTRL_WP];
            end
        end else if (start && (aw_addr == NSC_REG_ADDR)) begin
            blk_row <= w_data[15:0];
        end
    end

    // ***********************************************
    // pin sequencer
    // ***********************************************
    assign strobe_done = (tick == 4'(NSC_STROBE_CYC - 1));

    always_comb begin
        // row address selects page 0 or 1 of the block (block index times 64)
        unique case (addr_idx)
            3'd0: addr_byte = NSC_SPARE_COL[7:0];
            3'd1: addr_byte = NSC_SPARE_COL[15:8];
            3'd2: addr_byte = {blk_row[1:0], 5'h0, page2};
            3'd3: addr_byte = blk_row[9:2];
            default: addr_byte = (op == NSC_OP_ID) ? 8'h00 : {2'h0, blk_row[15:10]};
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= S_IDLE;
            op <= NSC_OP_RESET;
            cmd <= '0;
            addr_idx <= '0;
            addr_cnt <= '0;
            data_left <= '0;
            phase <= '0;
            tick <= '0;
            wait_cnt <= '0;
            busy <= 1'b0;
            timeout <= 1'b0;
            page2 <= 1'b0;
            id_pos <= '0;
            o_pins <= '{cs_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0, wr_n: 1'b1,
                        rd_n: 1'b1, wp_n: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
        end else begin
            o_pins.wp_n <= wp_release;
            unique case (state)
                S_IDLE: begin
                    o_pins.cs_n <= 1'b1;
                    if (start && (aw_addr == NSC_REG_CTRL) && w_data[NSC_CTRL_START]) begin
                        op <= w_data[NSC_CTRL_OP_LSB +: 3];
                        busy <= 1'b1;
                        timeout <= 1'b0;
                        page2 <= 1'b0;
                        id_pos <= '0;
                        state <= S_CMD;
                        unique case (w_data[NSC_CTRL_OP_LSB +: 3])
                            NSC_OP_RESET: cmd <= NSC_CMD_RESET;
                            NSC_OP_STATUS: cmd <= NSC_CMD_STATUS;
                            NSC_OP_ID: cmd <= NSC_CMD_ID;
                            default: cmd <= NSC_CMD_READ0;
                        endcase
                    end
                end
                S_CMD, S_CMD2, S_ADDR: begin
                    o_pins.cs_n <= 1'b0;
                    o_pins.dq_oe <= 1'b1;
                    o_pins.cmd_latch <= (state != S_ADDR);
                    o_pins.addr_latch <= (state == S_ADDR);
                    o_pins.dq_out <= (state == S_ADDR) ? addr_byte : cmd;
                    o_pins.wr_n <= (tick >= 4'(NSC_STROBE_CYC / 2));
                    tick <= strobe_done ? '0 : tick + 1'b1;
                    if (strobe_done) begin
                        o_pins.wr_n <= 1'b1;
                        wait_cnt <= '0;
                        if (state == S_CMD && op == NSC_OP_ID) begin
                            addr_cnt <= 3'd1;
                            addr_idx <= 3'd4;
                            state <= S_ADDR;
                        end else if (state == S_CMD && op >= NSC_OP_BADCHK) begin
                            addr_cnt <= 3'd5;
                            addr_idx <= '0;
                            state <= S_ADDR;
                        end else if (state == S_ADDR && addr_cnt != 3'd1) begin
                            addr_cnt <= addr_cnt - 1'b1;
                            addr_idx <= addr_idx + 1'b1;
                        end else if (state == S_ADDR && op != NSC_OP_ID) begin
                            cmd <= NSC_CMD_READ1;
                            state <= S_CMD2;
                        end else begin
                            state <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    o_pins.cmd_latch <= 1'b0;
                    o_pins.addr_latch <= 1'b0;
                    o_pins.dq_oe <= 1'b0;
                    wait_cnt <= wait_cnt + 1'b1;
                    // busy may only appear a while after the strobe, so the pin is ignored first
                    if (wait_cnt >= 32'(NSC_WB_CYC)) begin
                        if (i_ready_busy_n || op == NSC_OP_STATUS || op == NSC_OP_ID) begin
                            data_left <= (op == NSC_OP_ID) ? 3'd4 : 3'd1;
                            state <= (op == NSC_OP_RESET) ? S_DONE : S_DATA;
                        end else if (wait_cnt >= 32'(RST_TMO_CYC)) begin
                            timeout <= 1'b1;
                            state <= S_DONE;
                        end
                    end
                end
                S_DATA: begin
                    o_pins.rd_n <= (tick < 4'(NSC_STROBE_CYC / 2));
                    tick <= strobe_done ? '0 : tick + 1'b1;
                    if (strobe_done) begin
                        o_pins.rd_n <= 1'b1;
                        data_left <= data_left - 1'b1;
                        id_pos <= id_pos + 1'b1;
                        // single-byte reads stop here unless an erased page-one marker sends a bad check to page two; the page never rolls over
                        if (data_left == 3'd1) begin
                            if (op == NSC_OP_BADCHK && i_dq == NSC_ERASED && !page2) begin
                                page2 <= 1'b1;
                                cmd <= NSC_CMD_READ0;
                                state <= S_CMD;
                            end else begin
                                state <= S_DONE;
                            end
                        end
                    end
                end
                S_DONE: begin
                    o_pins.cs_n <= 1'b1;
                    busy <= 1'b0;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ***********************************************
    // captured results
    // ***********************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_byte <= '0;
            id_word <= '0;
            bad_flag <= 1'b0;
            checked <= 1'b0;
        end else if (state == S_DATA && strobe_done) begin
            if (op == NSC_OP_STATUS) begin
                status_byte <= i_dq;
            end
            if (op == NSC_OP_ID) begin
                id_word[8*id_pos +: 8] <= i_dq;
            end
            if (op == NSC_OP_BADCHK && data_left == 3'd1) begin
                // block zero is taken as good whatever the marker says
                bad_flag <= (i_dq != NSC_ERASED) && (blk_row != 16'h0);
                checked <= 1'b1;
            end
        end
    end

    // ***********************************************
    // page data fifo
    // ***********************************************
    assign fifo_in_valid = (state == S_DATA) && strobe_done && (op == NSC_OP_READ);

    nsc_fifo #(
        .WIDTH(8),
        .DEPTH(NSC_FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_valid(fifo_in_valid),
        .i_data(i_dq),
        .o_ready(fifo_in_ready),
        .o_valid(fifo_out_valid),
        .o_data(fifo_out_data),
        .i_ready(fifo_pop)
    );
endmodule
`default_nettype wire

// File: verilog/nsc_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module nsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_valid = (count != '0);
    assign o_data = mem[rd_ptr];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
